// file: logic/ddrc_pkg.sv
// shared constants and types of the clock and reset generator
// assumes every derived waveform is produced on the single reference clock
package ddrc_pkg;

  // one full-rate period is split into this many phase steps
  localparam int PHASES = 16;
  localparam int PH_W = 4;
  localparam int HR_W = PH_W + 1;

  localparam int REF_CLK_PERIOD_NS = 5;
  localparam int REF_CLK_MHZ = 200;

  // lock settling time after a (re)start of the generator
  localparam int LOCK_TIME_NS = 320;
  localparam int LOCK_CYCLES = (LOCK_TIME_NS + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS;
  localparam int LOCK_W = 8;

  // scan clock: half-rate system clock divided by SCAN_DIV
  localparam int SCAN_MAX_MHZ = 100;
  localparam int SCAN_DIV = 2;
  localparam int SCAN_RATIO = 2 * PHASES * SCAN_DIV;

  // phase offsets in steps, positive means earlier
  localparam logic [PH_W-1:0] MEM_OFF = 4'h0;
  localparam logic [PH_W-1:0] WR_LEAD = 4'h4;
  localparam logic [PH_W-1:0] HALF_TURN = 4'h8;
  localparam logic [PH_W-1:0] RESYNC_RST_OFF = 4'h0;
  localparam logic [PH_W-1:0] MEASURE_RST_OFF = 4'h0;
  localparam logic [PH_W-1:0] AC_TRIM_RST = 4'h0;
  localparam logic [HR_W-1:0] SYS_OFF = 5'h00;

  typedef enum logic [1:0] {
    AC_0   = 2'h0,
    AC_90  = 2'h1,
    AC_180 = 2'h2,
    AC_270 = 2'h3
  } ddrc_ac_phase_e;

  typedef enum logic [1:0] {
    SH_RESYNC  = 2'h0,
    SH_MEASURE = 2'h1,
    SH_ADDR_CMD = 2'h2,
    SH_NONE    = 2'h3
  } ddrc_shift_sel_e;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'h1,
    ST_LOCKING = 3'h2,
    ST_LOCKED  = 3'h4
  } ddrc_state_e;

endpackage

// file: logic/ddrc_phase_out.sv
// one phase-shifted clock waveform plus its domain reset
// assumes base advances by one every reference cycle while run is high
`timescale 1ns/1ps
`default_nettype none
module ddrc_phase_out #(
  parameter int W = 4
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic run,
  input wire logic [W-1:0] base,
  input wire logic [W-1:0] offset,
  output logic clk_q,
  output logic rst_q
);
  logic [W-1:0] pos;
  logic wave;

  assign pos = base + offset;
  // high in the first half of each period
  assign wave = ~pos[W-1];

  always_ff @(posedge clk) begin
    if (srst || !run) begin
      clk_q <= 1'b0;
    end else begin
      clk_q <= wave;
    end
  end

  // release only on this clock's own rising edge
  always_ff @(posedge clk) begin
    if (srst || !run) begin
      rst_q <= 1'b1;
    end else if (wave && !clk_q) begin
      rst_q <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: logic/ddrc_clk_rst_gen.sv
// clock and reset generator of the memory phy: phased clocks, scan clock, domain resets
// assumes step requests come from logic on REF_CLK; GLOBAL_RESET_N is an async pin
//
// What this block does
// - The generator offers at least 16 selectable phase steps of its fastest clock.
// - A low global reset restarts the generator and relocks so all phases are re-set.
// - The scan clock is the half-rate system clock divided down, kept below 100 MHz.
// - The write-data clock leads the full-rate memory clock by 90 degrees.
// - The addr/cmd clock comes from the memory clock at 0/180 and the write clock at 90/270.
// - The chip-select clock is made with the addr/cmd clock's offset and follows its phase.
// - The read resync clock phase is held where calibration centres it in the data window.
// - A free-running vt measurement clock is provided for drift tracking.
// - Calibration and tracking can shift selected clock phases at run time.
// - Half-rate clocks run at half the memory clock rate, full-rate ones at its rate.
`timescale 1ns/1ps
`default_nettype none
module ddrc_clk_rst_gen (
  input wire logic REF_CLK,
  input wire logic SRST,
  input wire logic GLOBAL_RESET_N,
  input wire ddrc_pkg::ddrc_ac_phase_e AC_PHASE_SEL,
  input wire logic PHASE_STEP,
  input wire ddrc_pkg::ddrc_shift_sel_e PHASE_SEL,
  input wire logic PHASE_UP,
  output logic PHASE_DONE,
  output logic PLL_LOCKED,
  output logic HALF_RATE_SYSTEM_CLOCK,
  output logic HALF_RATE_MEMORY_CLOCK,
  output logic FULL_RATE_MEMORY_CLOCK,
  output logic WRITE_DATA_CLOCK,
  output logic ADDR_CMD_CLOCK,
  output logic CHIP_SELECT_CLOCK,
  output logic READ_RESYNC_CLOCK,
  output logic VT_MEASURE_CLOCK,
  output logic SCAN_CLOCK,
  output logic SYS_RST,
  output logic MEM_RST,
  output logic WRITE_RST,
  output logic ADDR_CMD_RST,
  output logic RESYNC_RST,
  output logic MEASURE_RST
);
  import ddrc_pkg::*;

  ddrc_state_e state_q;
  logic gr_meta_q;
  logic gr_sync_q;
  logic [LOCK_W-1:0] lock_cnt_q;
  logic locked_q;
  logic [HR_W-1:0] base_q;
  logic [PH_W-1:0] resync_off_q;
  logic [PH_W-1:0] measure_off_q;
  logic [PH_W-1:0] ac_trim_q;
  logic [PH_W-1:0] ac_src_off;
  logic [PH_W-1:0] ac_off;
  logic step_ok;
  logic done_q;
  logic sys_prev_q;
  logic scan_q;
  logic meas_prev_q;
  logic meas_step_q;
  logic [4:0] meas_gap_q;

  // pin crosses two flops before anything reads it
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      gr_meta_q <= 1'b0;
      gr_sync_q <= 1'b0;
    end else begin
      gr_meta_q <= GLOBAL_RESET_N;
      gr_sync_q <= gr_meta_q;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST || !gr_sync_q) begin
      state_q <= ST_IDLE;
      lock_cnt_q <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          state_q <= ST_LOCKING;
          lock_cnt_q <= '0;
        end
        ST_LOCKING: begin
          if (lock_cnt_q == LOCK_W'(LOCK_CYCLES - 1)) begin
            state_q <= ST_LOCKED;
          end
          lock_cnt_q <= lock_cnt_q + 1'b1;
        end
        ST_LOCKED: begin
          state_q <= ST_LOCKED;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  assign locked_q = (state_q == ST_LOCKED);
  assign PLL_LOCKED = locked_q;

  // phase counter restarts at zero on every relock, so all phases re-align
  always_ff @(posedge REF_CLK) begin
    if (SRST || !locked_q) begin
      base_q <= '0;
    end else begin
      base_q <= base_q + 1'b1;
    end
  end

  assign step_ok = PHASE_STEP && locked_q;

  // run-time phase moves, one step per request
  always_ff @(posedge REF_CLK) begin
    if (SRST || !locked_q) begin
      resync_off_q <= RESYNC_RST_OFF;
      measure_off_q <= MEASURE_RST_OFF;
      ac_trim_q <= AC_TRIM_RST;
    end else if (step_ok) begin
      case (PHASE_SEL)
        SH_RESYNC: resync_off_q <= PHASE_UP ? resync_off_q + 1'b1 : resync_off_q - 1'b1;
        SH_MEASURE: measure_off_q <= PHASE_UP ? measure_off_q + 1'b1 : measure_off_q - 1'b1;
        SH_ADDR_CMD: ac_trim_q <= PHASE_UP ? ac_trim_q + 1'b1 : ac_trim_q - 1'b1;
        default: ac_trim_q <= ac_trim_q;
      endcase
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      done_q <= 1'b0;
    end else begin
      done_q <= step_ok;
    end
  end

  assign PHASE_DONE = done_q;

  // source is the memory or write clock, the other two settings invert it
  always_comb begin
    ac_src_off = MEM_OFF;
    if (AC_PHASE_SEL == AC_90 || AC_PHASE_SEL == AC_270) begin
      ac_src_off = MEM_OFF + WR_LEAD;
    end
    ac_off = ac_src_off + ac_trim_q;
    if (AC_PHASE_SEL == AC_90 || AC_PHASE_SEL == AC_180) begin
      ac_off = ac_src_off + ac_trim_q + HALF_TURN;
    end
  end

  // half-rate uses the full counter, full-rate its low bits
  ddrc_phase_out #(.W(HR_W)) u_sys (
    .clk(REF_CLK), .srst(SRST), .run(locked_q), .base(base_q), .offset(SYS_OFF),
    .clk_q(HALF_RATE_SYSTEM_CLOCK), .rst_q(SYS_RST));
  ddrc_phase_out #(.W(HR_W)) u_hmem (
    .clk(REF_CLK), .srst(SRST), .run(locked_q), .base(base_q), .offset(SYS_OFF),
    .clk_q(HALF_RATE_MEMORY_CLOCK), .rst_q());
  ddrc_phase_out #(.W(PH_W)) u_mem (
    .clk(REF_CLK), .srst(SRST), .run(locked_q), .base(base_q[PH_W-1:0]), .offset(MEM_OFF),
    .clk_q(FULL_RATE_MEMORY_CLOCK), .rst_q(MEM_RST));
  ddrc_phase_out #(.W(PH_W)) u_wr (
    .clk(REF_CLK), .srst(SRST), .run(locked_q), .base(base_q[PH_W-1:0]),
    .offset(MEM_OFF + WR_LEAD), .clk_q(WRITE_DATA_CLOCK), .rst_q(WRITE_RST));
  ddrc_phase_out #(.W(PH_W)) u_ac (
    .clk(REF_CLK), .srst(SRST), .run(locked_q), .base(base_q[PH_W-1:0]), .offset(ac_off),
    .clk_q(ADDR_CMD_CLOCK), .rst_q(ADDR_CMD_RST));
  // same offset as addr/cmd so chip select never drifts from it
  ddrc_phase_out #(.W(PH_W)) u_cs (
    .clk(REF_CLK), .srst(SRST), .run(locked_q), .base(base_q[PH_W-1:0]), .offset(ac_off),
    .clk_q(CHIP_SELECT_CLOCK), .rst_q());
  ddrc_phase_out #(.W(PH_W)) u_rsy (
    .clk(REF_CLK), .srst(SRST), .run(locked_q), .base(base_q[PH_W-1:0]),
    .offset(resync_off_q), .clk_q(READ_RESYNC_CLOCK), .rst_q(RESYNC_RST));
  ddrc_phase_out #(.W(PH_W)) u_mea (
    .clk(REF_CLK), .srst(SRST), .run(locked_q), .base(base_q[PH_W-1:0]),
    .offset(measure_off_q), .clk_q(VT_MEASURE_CLOCK), .rst_q(MEASURE_RST));

  // divide by SCAN_DIV on rising half-rate edges; ratio SCAN_RATIO keeps it far below the limit
  always_ff @(posedge REF_CLK) begin
    if (SRST || !locked_q) begin
      sys_prev_q <= 1'b0;
      scan_q <= 1'b0;
    end else begin
      sys_prev_q <= HALF_RATE_SYSTEM_CLOCK;
      if (HALF_RATE_SYSTEM_CLOCK && !sys_prev_q) begin
        scan_q <= ~scan_q;
      end
    end
  end

  assign SCAN_CLOCK = scan_q;

  // cycles since the last measure rise; a later step stretches one period, so a taken
  // measure step restarts the count one cycle after it lands
  always_ff @(posedge REF_CLK) begin
    if (SRST || !locked_q) begin
      meas_prev_q <= 1'b0;
      meas_step_q <= 1'b0;
      meas_gap_q <= '0;
    end else begin
      meas_prev_q <= VT_MEASURE_CLOCK;
      meas_step_q <= step_ok && (PHASE_SEL == SH_MEASURE);
      if ((VT_MEASURE_CLOCK && !meas_prev_q) || meas_step_q) begin
        meas_gap_q <= '0;
      end else if (meas_gap_q != 5'h1F) begin
        meas_gap_q <= meas_gap_q + 5'h01;
      end
    end
  end

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (SRST);

  sequence s_mem_rise;
    $rose(FULL_RATE_MEMORY_CLOCK);
  endsequence

  a_write_lead_mem: assert property (
    locked_q && $past(locked_q, 6) |-> FULL_RATE_MEMORY_CLOCK == $past(WRITE_DATA_CLOCK, 4))
    else $error("write clock does not lead memory clock by a quarter period");
  a_full_rate_period: assert property (
    (locked_q and s_mem_rise) |-> ##16 (!locked_q || $rose(FULL_RATE_MEMORY_CLOCK)))
    else $error("full-rate clock period wrong");
  a_half_rate_period: assert property (
    locked_q && $rose(HALF_RATE_SYSTEM_CLOCK) |-> ##16 (!locked_q || $fell(HALF_RATE_SYSTEM_CLOCK))
      ##16 (!locked_q || $rose(HALF_RATE_SYSTEM_CLOCK)))
    else $error("half-rate clock period wrong");
  a_scan_toggle: assert property (
    locked_q && $rose(HALF_RATE_SYSTEM_CLOCK) |=> !locked_q || $changed(SCAN_CLOCK))
    else $error("scan clock did not follow half-rate edge");
  a_relock_on_reset: assert property (
    !gr_sync_q |=> !PLL_LOCKED [*8])
    else $error("global reset did not drop lock");
  a_ac_from_mem: assert property (
    locked_q && $past(locked_q) && AC_PHASE_SEL == AC_0 && $past(AC_PHASE_SEL) == AC_0
      && $past(ac_trim_q) == 4'h0 |-> ADDR_CMD_CLOCK == FULL_RATE_MEMORY_CLOCK)
    else $error("addr/cmd clock not sourced from memory clock");
  a_ac_from_write: assert property (
    locked_q && $past(locked_q) && AC_PHASE_SEL == AC_270 && $past(AC_PHASE_SEL) == AC_270
      && $past(ac_trim_q) == 4'h0 |-> ADDR_CMD_CLOCK == WRITE_DATA_CLOCK)
    else $error("addr/cmd clock not sourced from write clock");
  a_cs_follows_ac: assert property (
    CHIP_SELECT_CLOCK == ADDR_CMD_CLOCK)
    else $error("chip-select clock differs from addr/cmd clock");
  a_resync_step: assert property (
    step_ok && PHASE_SEL == SH_RESYNC && PHASE_UP
      |=> PHASE_DONE && (!locked_q || resync_off_q == $past(resync_off_q) + 4'h1))
    else $error("resync phase step not applied");
  a_measure_runs: assert property (
    meas_gap_q <= 5'h0F)
    else $error("measurement clock stopped");
  a_rst_until_lock: assert property (
    !$past(locked_q) |-> SYS_RST && MEM_RST && WRITE_RST && ADDR_CMD_RST && RESYNC_RST
      && MEASURE_RST)
    else $error("domain reset released before lock");
endmodule
`default_nettype wire

// file: test/ddrc_cal_model.sv
// calibration sequencer model: drives phase step pulses
// assumes req comes from the bench on clk; select and direction idle between steps
`timescale 1ns/1ps
`default_nettype none
module ddrc_cal_model (
  input wire logic clk,
  input wire logic req,
  input wire ddrc_pkg::ddrc_shift_sel_e sel,
  input wire logic up,
  output logic step_q,
  output ddrc_pkg::ddrc_shift_sel_e sel_q,
  output logic up_q
);
  import ddrc_pkg::*;
  // idle lines move so a stale value never looks valid
  always_ff @(posedge clk) begin
    step_q <= req;
    sel_q <= req ? sel : SH_NONE;
    up_q <= req ? up : ~up;
  end
endmodule
`default_nettype wire

// file: test/tb_top.sv
// testbench of the clock and reset generator: phases, rates, steps, relock
// assumes the sequencer model drives the step port
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fail_count++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
  import ddrc_pkg::*;
  logic REF_CLK, SRST, GLOBAL_RESET_N, req, up, PHASE_STEP, PHASE_UP, PHASE_DONE, PLL_LOCKED;
  ddrc_ac_phase_e AC_PHASE_SEL;
  ddrc_shift_sel_e sel, PHASE_SEL;
  logic [8:0] v;
  logic mr, sr, wr, ar, rr, vr;
  int fail_count, n_compared, g, i;
  // ac sel, from clock, to clock, cycles between rises
  int rows [11][4] = '{'{0, 0, 0, 16}, '{0, 6, 6, 32}, '{0, 7, 7, 32}, '{0, 8, 8, 64},
    '{0, 0, 1, 12}, '{0, 0, 3, 0}, '{0, 0, 4, 0}, '{0, 0, 2, 0}, '{1, 0, 2, 4},
    '{2, 0, 2, 8}, '{3, 0, 2, 12}};
  ddrc_clk_rst_gen u_ddrc_clk_rst_gen (.REF_CLK(REF_CLK), .SRST(SRST),
    .GLOBAL_RESET_N(GLOBAL_RESET_N), .AC_PHASE_SEL(AC_PHASE_SEL), .PHASE_STEP(PHASE_STEP),
    .PHASE_SEL(PHASE_SEL), .PHASE_UP(PHASE_UP), .PHASE_DONE(PHASE_DONE),
    .PLL_LOCKED(PLL_LOCKED), .HALF_RATE_SYSTEM_CLOCK(v[6]), .HALF_RATE_MEMORY_CLOCK(v[7]),
    .FULL_RATE_MEMORY_CLOCK(v[0]), .WRITE_DATA_CLOCK(v[1]), .ADDR_CMD_CLOCK(v[2]),
    .CHIP_SELECT_CLOCK(v[5]), .READ_RESYNC_CLOCK(v[3]), .VT_MEASURE_CLOCK(v[4]),
    .SCAN_CLOCK(v[8]), .SYS_RST(sr), .MEM_RST(mr), .WRITE_RST(wr), .ADDR_CMD_RST(ar),
    .RESYNC_RST(rr), .MEASURE_RST(vr));
  ddrc_cal_model u_ddrc_cal_model (.clk(REF_CLK), .req(req), .sel(sel), .up(up),
    .step_q(PHASE_STEP), .sel_q(PHASE_SEL), .up_q(PHASE_UP));
  initial begin
    REF_CLK = 1'b0;
    forever #2.5 REF_CLK = ~REF_CLK;
  end
  task end_sim;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // f=1 uses the synchronous reset, f=0 the global pin
  task drop(input ddrc_ac_phase_e a, input logic f);
    @(posedge REF_CLK);
    {SRST, GLOBAL_RESET_N} <= f ? 2'b11 : 2'b00;
    AC_PHASE_SEL <= a;
    repeat (4) @(posedge REF_CLK);
    @(negedge REF_CLK);
    `CHK({PLL_LOCKED, PHASE_DONE, v, mr, sr}, 13'h003)
    @(posedge REF_CLK);
    {SRST, GLOBAL_RESET_N} <= 2'b01;
  endtask
  task lock;
    int k;
    for (k = 0; k < 100 && PLL_LOCKED !== 1'b1; k++) @(negedge REF_CLK);
    `CHK(PLL_LOCKED, 1'b1)
    for (k = 0; k < 40 && mr !== 1'b0; k++) @(negedge REF_CLK);
    `CHK({mr, sr, v[0], v[6]}, 4'h3)
    `CHK({wr, rr, vr, v[1], v[3], v[4]}, 6'h07)
    for (k = 0; k < 16 && ar !== 1'b0; k++) @(negedge REF_CLK);
    `CHK({ar, v[2], v[5]}, 3'h3)
  endtask
  task gap(input int a, input int b, output int d);
    logic pa, pb;
    int k;
    d = -1;
    pa = v[a];
    pb = v[b];
    for (k = 0; k < 160; k++) begin
      @(negedge REF_CLK);
      if (d >= 0) d++;
      else if (!pa && v[a]) d = 0;
      if (d >= 0 && (d > 0 || a != b) && !pb && v[b]) break;
      if (b == 2) `CHK(v[5], v[2])
      pa = v[a];
      pb = v[b];
    end
  endtask
  // done must follow each taken step by exactly one cycle
  task steps(input ddrc_shift_sel_e s, input logic u, input int n, input int e);
    int c, k;
    logic pv;
    c = 0;
    pv = 1'b0;
    for (k = 0; k < n + 5; k++) begin
      @(posedge REF_CLK);
      req <= (k < n);
      sel <= s;
      up <= u;
      @(negedge REF_CLK);
      `CHK(PHASE_DONE, pv)
      c += PHASE_DONE;
      pv = PHASE_STEP & PLL_LOCKED;
    end
    `CHK(c, e)
  endtask
  task chk_gap(input int b, input int e);
    gap(0, b, g);
    `CHK(g, e)
  endtask
  initial begin
    fail_count = 0;
    n_compared = 0;
    SRST = 1'b1;
    GLOBAL_RESET_N = 1'b1;
    AC_PHASE_SEL = AC_0;
    req = 1'b0;
    sel = SH_NONE;
    up = 1'b0;
    drop(AC_0, 1'b1);
    lock();
    for (i = 0; i < 11; i++) begin
      if (rows[i][0] != AC_PHASE_SEL) begin
        drop(ddrc_ac_phase_e'(rows[i][0]), 1'b0);
        lock();
      end
      gap(rows[i][1], rows[i][2], g);
      `CHK(g, rows[i][3])
    end
    drop(AC_0, 1'b0);
    steps(SH_RESYNC, 1'b1, 1, 0);
    lock();
    chk_gap(3, 0);
    steps(SH_RESYNC, 1'b1, 1, 1);
    chk_gap(3, 15);
    steps(SH_MEASURE, 1'b1, 2, 2);
    chk_gap(4, 14);
    steps(SH_ADDR_CMD, 1'b0, 3, 3);
    chk_gap(2, 3);
    steps(SH_NONE, 1'b1, 1, 1);
    chk_gap(3, 15);
    steps(SH_RESYNC, 1'b1, 16, 16);
    chk_gap(3, 15);
    drop(AC_0, 1'b0);
    lock();
    chk_gap(3, 0);
    steps(SH_MEASURE, 1'b0, 1, 1);
    drop(AC_0, 1'b1);
    lock();
    chk_gap(4, 0);
    end_sim();
  end
  initial begin
    #300000;
    fail_count++;
    end_sim();
  end
endmodule
`default_nettype wire
